/* File: logic/stepper_core.sv */
// Stepper translator, PWM current regulator and pre-driver control.
// Assumes the step, direction, clear, chip select and comparator inputs are asynchronous pins.
`default_nettype none
`timescale 1ns/100ps
module stepper_core
  import stepper_pkg::*;
#(
  parameter int PWM_PERIOD = PWM_PERIOD_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_chip_select_n,
  input wire logic i_step_pulse_in,
  input wire logic i_dir_pin,
  input wire logic i_clear_input,
  input wire logic i_x_over_cur,
  input wire logic i_y_over_cur,
  input wire logic i_sdo_level,
  input wire logic i_watchdog_out_n,
  input wire logic i_fault_out_n,
  output logic [7:0] o_table_position,
  output logic [7:0] o_x_setpoint,
  output logic o_x_negative,
  output logic [7:0] o_y_setpoint,
  output logic o_y_negative,
  output logic o_bridge_enable,
  output logic [3:0] o_slope_on_code,
  output logic [3:0] o_slope_off_code,
  output logic [3:0] o_hs_src_up,
  output logic [3:0] o_hs_src_dn,
  output logic [3:0] o_hs_sw_up,
  output logic [3:0] o_hs_sw_dn,
  output logic [3:0] o_ls_src_up,
  output logic [3:0] o_ls_src_dn,
  output logic [3:0] o_ls_sw_up,
  output logic [3:0] o_ls_sw_dn,
  output logic [2:0] o_pin_out,
  output logic [2:0] o_pin_oe_n
);
  // Synchronisers: cs_n, step, dir, clear, x over, y over
  logic [5:0] sync1_q, sync2_q;
  logic step_prev_q, cs_prev_q;
  logic [31:0] ctrl_sh_q, slope_sh_q, timing_sh_q;
  logic [31:0] ctrl_q, slope_q, timing_q;
  logic [7:0] pos_q, pos_d;
  logic [15:0] pwm_cnt_q, pwm_cnt_d;
  logic [7:0] lfsr_q;
  logic [1:0] pwm_on_q, pwm_on_d;
  logic [31:0] rdata_d;

  wire cs_s = sync2_q[0];
  wire step_s = sync2_q[1];
  wire dir_s = sync2_q[2];
  wire clear_s = sync2_q[3];
  wire [1:0] over_s = sync2_q[5:4];

  wire [2:0] res = ctrl_q[CTRL_RES_LSB +: 3];
  wire drv_en = ctrl_q[CTRL_EN_BIT];
  wire rev_en = ctrl_q[CTRL_REV_BIT];
  wire jit_en = ctrl_q[CTRL_JIT_BIT];
  wire edge_fall = ctrl_q[CTRL_EDGE_BIT];
  wire [2:0] odrain = ctrl_q[CTRL_ODRAIN_LSB +: 3];
  wire [7:0] dead_w = dead_cycles(ctrl_q[CTRL_DEAD_LSB +: 2]);

  wire cs_rise = cs_s && !cs_prev_q;
  wire step_rise = step_s && !step_prev_q;
  wire step_fall = !step_s && step_prev_q;
  wire step_evt = edge_fall ? step_fall : step_rise;
  wire backward = dir_s || rev_en;
  wire [7:0] step_w = step_size(res);
  wire period_start = (pwm_cnt_q == 16'h0000);
  wire [15:0] period_len = 16'(PWM_PERIOD - 1) + (jit_en ? {10'h000, lfsr_q[JITTER_BITS-1:0]} : 16'h0000);

  // Quarter-wave sine magnitude, k in 0..64, full scale COIL_MAX
  function automatic logic [7:0] sine_mag(input logic [6:0] k);
    logic [12:0] u;
    logic [24:0] num;
    logic [16:0] den;
    logic [24:0] quo;
    begin
      u = 13'({6'h00, k} * (13'h0080 - {6'h00, k}));
      num = 25'({12'h000, u} * SINE_NUM_K);
      den = SINE_DEN_K - {2'b00, u, 2'b00};
      quo = num / {8'h00, den};
      sine_mag = (quo > {17'h00000, COIL_MAX}) ? COIL_MAX : quo[7:0];
    end
  endfunction

  // Position to {x_neg, x_mag, y_neg, y_mag}
  function automatic logic [17:0] coil_point(input logic [7:0] pos, input logic [2:0] r);
    logic [1:0] q;
    logic [6:0] k;
    logic [7:0] a, b, xm, ym, p2;
    logic xn, yn;
    begin
      q = pos[7:6];
      k = {1'b0, pos[5:0]};
      a = sine_mag(k);
      b = sine_mag(POS_QUARTER - k);
      xn = q[1];
      yn = q[0] ^ q[1];
      xm = q[0] ? b : a;
      ym = q[0] ? a : b;
      p2 = pos + FULL_OFFSET;
      if (res_type'(r) == RES_HALF_UNC) begin
        xm = (xm != 8'h00) ? COIL_MAX : 8'h00;
        ym = (ym != 8'h00) ? COIL_MAX : 8'h00;
      end
      if (res_type'(r) == RES_FULL) begin
        xn = p2[7];
        yn = p2[7] ^ p2[6];
        xm = COIL_MAX;
        ym = COIL_MAX;
      end
      coil_point = {xn, xm, yn, ym};
    end
  endfunction

  wire [17:0] point_w = coil_point(pos_q, res);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 6'h01;
      sync2_q <= 6'h01;
      step_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q <= {i_y_over_cur, i_x_over_cur, i_clear_input, i_dir_pin, i_step_pulse_in, i_chip_select_n};
      sync2_q <= sync1_q;
      step_prev_q <= step_s;
      cs_prev_q <= cs_s;
    end
  end

  // Register port: shadow on write, live copy when chip select rises
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_sh_q <= CTRL_RESET;
      slope_sh_q <= SLOPE_RESET;
      timing_sh_q <= TIMING_RESET;
      ctrl_q <= CTRL_RESET;
      slope_q <= SLOPE_RESET;
      timing_q <= TIMING_RESET;
    end else begin
      if (i_wr && i_addr == REG_CTRL) ctrl_sh_q <= i_wdata;
      if (i_wr && i_addr == REG_SLOPE) slope_sh_q <= i_wdata;
      if (i_wr && i_addr == REG_TIMING) timing_sh_q <= i_wdata;
      if (cs_rise) begin
        ctrl_q <= ctrl_sh_q;
        slope_q <= slope_sh_q;
        timing_q <= timing_sh_q;
      end
    end
  end

  always_comb begin
    case (i_addr)
      REG_CTRL: rdata_d = ctrl_sh_q;
      REG_SLOPE: rdata_d = slope_sh_q;
      REG_TIMING: rdata_d = timing_sh_q;
      REG_POSITION: rdata_d = {24'h000000, pos_q};
      REG_SETPOINT: rdata_d = {14'h0000, o_x_negative, o_x_setpoint, o_y_negative, o_y_setpoint};
      default: rdata_d = 32'h0000_0000;
    endcase
    if (!i_rd) rdata_d = 32'h0000_0000;
  end

  // Translator; 8-bit arithmetic wraps both ways
  assign pos_d = clear_s ? 8'h00 :
                 !(step_evt && drv_en) ? pos_q :
                 backward ? pos_q - step_w : pos_q + step_w;

  // PWM: fixed period from the core clock, optional LFSR jitter
  assign pwm_cnt_d = period_start ? period_len : pwm_cnt_q - 16'h0001;

  // Set at period start wins over comparator trip
  always_comb begin
    pwm_on_d = pwm_on_q & ~over_s;
    if (period_start) begin
      pwm_on_d[0] = (point_w[16:9] != 8'h00);
      pwm_on_d[1] = (point_w[7:0] != 8'h00);
    end
    if (!drv_en) pwm_on_d = 2'b00;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_q <= 8'h00;
      pwm_cnt_q <= 16'h0000;
      lfsr_q <= 8'h01;
      pwm_on_q <= 2'b00;
      o_rdata <= 32'h0000_0000;
      {o_x_negative, o_x_setpoint, o_y_negative, o_y_setpoint} <= 18'h00000;
      o_table_position <= 8'h00;
      o_bridge_enable <= 1'b0;
      o_slope_on_code <= 4'h0;
      o_slope_off_code <= 4'h0;
    end else begin
      pos_q <= pos_d;
      pwm_cnt_q <= pwm_cnt_d;
      if (period_start) begin
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        {o_x_negative, o_x_setpoint, o_y_negative, o_y_setpoint} <= point_w;
      end
      pwm_on_q <= pwm_on_d;
      o_rdata <= rdata_d;
      o_table_position <= pos_d;
      o_bridge_enable <= drv_en;
      o_slope_on_code <= slope_q[SLOPE_ON_LSB +: 4];
      o_slope_off_code <= slope_q[SLOPE_OFF_LSB +: 4];
    end
  end

  // Output pin stages: open-drain drives low only, push-pull always drives
  wire [2:0] pin_level = {i_fault_out_n, i_watchdog_out_n, i_sdo_level};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_pin_out[gi] <= 1'b1;
          o_pin_oe_n[gi] <= 1'b1;
        end else begin
          o_pin_out[gi] <= odrain[gi] ? 1'b0 : pin_level[gi];
          o_pin_oe_n[gi] <= odrain[gi] ? pin_level[gi] : 1'b0;
        end
      end
    end
    // Half bridges: 0 X N-side, 1 X P-side, 2 Y N-side, 3 Y P-side
    for (gi = 0; gi < 4; gi++) begin : g_bridge
      wire neg = (gi < 2) ? o_x_negative : o_y_negative;
      wire demand = pwm_on_q[gi / 2] && (neg ^ (gi % 2 == 1));
      gate_sequencer u_seq (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_enable(drv_en),
        .i_demand_high(demand),
        .i_t1(timing_q[TIM_T1_LSB +: 8]),
        .i_t2(timing_q[TIM_T2_LSB +: 8]),
        .i_toff(timing_q[TIM_OFF_LSB +: 8]),
        .i_dead(dead_w),
        .o_hs_src_up(o_hs_src_up[gi]),
        .o_hs_src_dn(o_hs_src_dn[gi]),
        .o_hs_sw_up(o_hs_sw_up[gi]),
        .o_hs_sw_dn(o_hs_sw_dn[gi]),
        .o_ls_src_up(o_ls_src_up[gi]),
        .o_ls_src_dn(o_ls_src_dn[gi]),
        .o_ls_sw_up(o_ls_sw_up[gi]),
        .o_ls_sw_dn(o_ls_sw_dn[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_clear_zero;
    clear_s |=> (pos_q == 8'h00) && (o_table_position == 8'h00);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero position");

  property p_fwd_step;
    step_evt && drv_en && !backward && !clear_s |=> pos_q == 8'($past(pos_q) + $past(step_w));
  endproperty
  a_fwd_step: assert property (p_fwd_step) else $error("forward step wrong");

  property p_back_step;
    step_evt && drv_en && backward && !clear_s |=> pos_q == 8'($past(pos_q) - $past(step_w));
  endproperty
  a_back_step: assert property (p_back_step) else $error("backward step wrong");

  property p_no_step_off;
    !step_evt && !clear_s |=> $stable(pos_q);
  endproperty
  a_no_step_off: assert property (p_no_step_off) else $error("position moved without step");

  property p_setpoint_hold;
    !period_start |=> $stable(o_x_setpoint) && $stable(o_y_setpoint);
  endproperty
  a_setpoint_hold: assert property (p_setpoint_hold) else $error("setpoint changed mid period");

  property p_pos0_point;
    period_start && pos_q == 8'h00 && res != RES_FULL |=> o_y_setpoint == COIL_MAX && o_x_setpoint == 8'h00;
  endproperty
  a_pos0_point: assert property (p_pos0_point) else $error("position zero setpoint wrong");

  property p_disabled_off;
    !drv_en |=> pwm_on_q == 2'b00 ##1 o_hs_sw_up == 4'h0;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("bridge active while disabled");

  property p_over_trip;
    over_s[0] && !period_start |=> !pwm_on_q[0];
  endproperty
  a_over_trip: assert property (p_over_trip) else $error("comparator did not end on time");

  property p_fixed_period;
    period_start && !jit_en |=> pwm_cnt_q == 16'(PWM_PERIOD - 1);
  endproperty
  a_fixed_period: assert property (p_fixed_period) else $error("PWM period not fixed");

  property p_cs_apply;
    !cs_rise |=> $stable(ctrl_q) && $stable(timing_q);
  endproperty
  a_cs_apply: assert property (p_cs_apply) else $error("setting applied before chip select high");

  property p_step_pulse;
    step_evt |=> !step_evt;
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step event longer than one cycle");

  property p_odrain;
    odrain[1] |=> o_pin_out[1] == 1'b0;
  endproperty
  a_odrain: assert property (p_odrain) else $error("open-drain pin drove high");

  c_fwd: cover property (step_evt && drv_en && !backward);
  c_back: cover property (step_evt && drv_en && backward);
  c_wrap: cover property (pos_q == 8'h00 ##1 pos_q == 8'hFF);
  c_apply: cover property (cs_rise && ctrl_sh_q != ctrl_q);
endmodule // stepper_core
`default_nettype wire

/* File: include/stepper_pkg.sv */
// Shared constants for the stepper translator and PWM core.
// Assumes a 200 MHz core clock; register indices are word indices on a plain port.
`default_nettype none
package stepper_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PWM_PERIOD_NS = 50000;
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int JITTER_BITS = 6;
  localparam int DEAD0_NS = 100;
  localparam int DEAD1_NS = 200;
  localparam int DEAD2_NS = 400;
  localparam int DEAD3_NS = 800;
  localparam int DEAD0_CYC = (DEAD0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD1_CYC = (DEAD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD2_CYC = (DEAD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD3_CYC = (DEAD3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SLOPE = 4'h1;
  localparam logic [3:0] REG_TIMING = 4'h2;
  localparam logic [3:0] REG_POSITION = 4'h3;
  localparam logic [3:0] REG_SETPOINT = 4'h4;

  // Control field positions
  localparam int CTRL_RES_LSB = 0;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_REV_BIT = 4;
  localparam int CTRL_JIT_BIT = 5;
  localparam int CTRL_DEAD_LSB = 6;
  localparam int CTRL_EDGE_BIT = 8;
  localparam int CTRL_ODRAIN_LSB = 9;
  localparam int SLOPE_ON_LSB = 0;
  localparam int SLOPE_OFF_LSB = 4;
  localparam int TIM_T1_LSB = 0;
  localparam int TIM_T2_LSB = 8;
  localparam int TIM_OFF_LSB = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SLOPE_RESET = 32'h0000_0088;
  localparam logic [31:0] TIMING_RESET = 32'h0010_0808;

  typedef enum logic [2:0] {
    RES_HALF_COMP = 3'h0, RES_QUARTER = 3'h1, RES_EIGHTH = 3'h2, RES_SIXTEENTH = 3'h3,
    RES_THIRTYSECOND = 3'h4, RES_SIXTYFOURTH = 3'h5, RES_HALF_UNC = 3'h6, RES_FULL = 3'h7
  } res_type;

  localparam logic [7:0] COIL_MAX = 8'hFF;
  localparam logic [6:0] POS_QUARTER = 7'h40;
  localparam logic [7:0] FULL_OFFSET = 8'h20;
  localparam logic [24:0] SINE_NUM_K = 25'h0000FF0;
  localparam logic [16:0] SINE_DEN_K = 17'h14000;

  typedef enum logic [3:0] {
    SEQ_LS_HARD = 4'h0, SEQ_LS_SLOPE_OFF = 4'h1, SEQ_DEAD_UP = 4'h3, SEQ_HS_ON1 = 4'h2,
    SEQ_HS_ON2 = 4'h6, SEQ_HS_HARD = 4'h7, SEQ_HS_SLOPE_OFF = 4'h5, SEQ_DEAD_DN = 4'h4,
    SEQ_LS_ON1 = 4'hC, SEQ_LS_ON2 = 4'h8, SEQ_OFF = 4'hF
  } seq_state_type;

  // Translator increment per step, in 1/64 microstep units
  function automatic logic [7:0] step_size(input logic [2:0] res);
    case (res_type'(res))
      RES_FULL: step_size = 8'h40;
      RES_HALF_COMP, RES_HALF_UNC: step_size = 8'h20;
      RES_QUARTER: step_size = 8'h10;
      RES_EIGHTH: step_size = 8'h08;
      RES_SIXTEENTH: step_size = 8'h04;
      RES_THIRTYSECOND: step_size = 8'h02;
      default: step_size = 8'h01;
    endcase
  endfunction

  function automatic logic [7:0] dead_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: dead_cycles = 8'(DEAD0_CYC);
      2'h1: dead_cycles = 8'(DEAD1_CYC);
      2'h2: dead_cycles = 8'(DEAD2_CYC);
      default: dead_cycles = 8'(DEAD3_CYC);
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: logic/gate_sequencer.sv */
// Gate sequencer for one external half bridge.
// Assumes durations are steady while a switching sequence runs.
`default_nettype none
`timescale 1ns/100ps
module gate_sequencer
  import stepper_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_demand_high,
  input wire logic [7:0] i_t1,
  input wire logic [7:0] i_t2,
  input wire logic [7:0] i_toff,
  input wire logic [7:0] i_dead,
  output logic o_hs_src_up,
  output logic o_hs_src_dn,
  output logic o_hs_sw_up,
  output logic o_hs_sw_dn,
  output logic o_ls_src_up,
  output logic o_ls_src_dn,
  output logic o_ls_sw_up,
  output logic o_ls_sw_dn
);
  seq_state_type state_q, state_d, flow;
  logic [7:0] cnt_q, cnt_d;
  wire done = (cnt_q == 8'h00);

  function automatic logic [7:0] dur(input seq_state_type s, input logic [7:0] t1, input logic [7:0] t2,
                                     input logic [7:0] toff, input logic [7:0] dead);
    case (s)
      SEQ_HS_ON1, SEQ_LS_ON1: dur = t1;
      SEQ_HS_ON2, SEQ_LS_ON2: dur = t2;
      SEQ_LS_SLOPE_OFF, SEQ_HS_SLOPE_OFF: dur = toff;
      SEQ_DEAD_UP, SEQ_DEAD_DN: dur = dead;
      default: dur = 8'h00;
    endcase
  endfunction

  // Slope phases (t1, t2 or toff), then hard switch; dead time between sides
  always_comb begin
    case (state_q)
      SEQ_OFF: flow = SEQ_LS_ON1;
      SEQ_LS_HARD: flow = i_demand_high ? SEQ_LS_SLOPE_OFF : SEQ_LS_HARD;
      SEQ_LS_SLOPE_OFF: flow = done ? SEQ_DEAD_UP : state_q;
      SEQ_DEAD_UP: flow = done ? SEQ_HS_ON1 : state_q;
      SEQ_HS_ON1: flow = done ? SEQ_HS_ON2 : state_q;
      SEQ_HS_ON2: flow = done ? SEQ_HS_HARD : state_q;
      SEQ_HS_HARD: flow = i_demand_high ? SEQ_HS_HARD : SEQ_HS_SLOPE_OFF;
      SEQ_HS_SLOPE_OFF: flow = done ? SEQ_DEAD_DN : state_q;
      SEQ_DEAD_DN: flow = done ? SEQ_LS_ON1 : state_q;
      SEQ_LS_ON1: flow = done ? SEQ_LS_ON2 : state_q;
      SEQ_LS_ON2: flow = done ? SEQ_LS_HARD : state_q;
      default: flow = SEQ_OFF;
    endcase
    state_d = i_enable ? flow : SEQ_OFF;
    if (state_d != state_q) begin
      cnt_d = dur(state_d, i_t1, i_t2, i_toff, i_dead);
    end else begin
      cnt_d = done ? cnt_q : cnt_q - 8'h01;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= SEQ_OFF;
      cnt_q <= 8'h00;
      {o_hs_src_up, o_hs_src_dn, o_hs_sw_up, o_hs_sw_dn} <= 4'h1;
      {o_ls_src_up, o_ls_src_dn, o_ls_sw_up, o_ls_sw_dn} <= 4'h1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      o_hs_src_up <= (state_d == SEQ_HS_ON1) || (state_d == SEQ_HS_ON2);
      o_hs_src_dn <= (state_d == SEQ_HS_SLOPE_OFF);
      o_hs_sw_up <= (state_d == SEQ_HS_HARD);
      o_hs_sw_dn <= !(state_d inside {SEQ_HS_ON1, SEQ_HS_ON2, SEQ_HS_SLOPE_OFF, SEQ_HS_HARD});
      o_ls_src_up <= (state_d == SEQ_LS_ON1) || (state_d == SEQ_LS_ON2);
      o_ls_src_dn <= (state_d == SEQ_LS_SLOPE_OFF);
      o_ls_sw_up <= (state_d == SEQ_LS_HARD);
      o_ls_sw_dn <= !(state_d inside {SEQ_LS_ON1, SEQ_LS_ON2, SEQ_LS_SLOPE_OFF, SEQ_LS_HARD});
    end
  end

  // Cycles with both sides held low, and the dead count loaded for this gap
  logic [7:0] gap_q, dead_len_q;
  wire both_off = o_hs_sw_dn && o_ls_sw_dn;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_q <= 8'h00;
      dead_len_q <= 8'h00;
    end else begin
      gap_q <= !both_off ? 8'h00 : (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
      if (state_d == SEQ_DEAD_UP && state_q != SEQ_DEAD_UP) dead_len_q <= i_dead;
    end
  end

  property p_dead_gap;
    @(posedge i_mclk) disable iff (!i_rst_n) $rose(o_hs_src_up) |-> gap_q > dead_len_q;
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("high side on before dead time elapsed");
endmodule // gate_sequencer
`default_nettype wire

/* File: dv/mcu_model.sv */
// Microcontroller side: step, direction and chip select pins.
// Assumes the caller sets the step idle level to suit the active edge.
`timescale 1ns/100ps
`default_nettype none
module mcu_model (
  output logic o_step,
  output logic o_dir,
  output logic o_cs_n
);
  logic idle;
  initial begin
    idle = 1'b0;
    o_step = 1'b0;
    o_dir = 1'b0;
    o_cs_n = 1'b1;
  end
  // Steps only start well after chip select is back high
  task automatic commit();
    o_cs_n <= 1'b0;
    #40 o_cs_n <= 1'b1;
    #60;
  endtask
  task automatic set_idle(input logic lvl);
    idle = lvl;
    o_step <= lvl;
    #100;
  endtask
  // Pin still between pulses; direction settled ahead of the edge
  task automatic pulse(input int n, input logic dir);
    o_dir <= dir;
    #40;
    repeat (n) begin
      o_step <= ~idle;
      #80 o_step <= idle;
      #80;
    end
  endtask
endmodule // mcu_model
`default_nettype wire

/* File: dv/tb_stepper_core.sv */
// Self-checking bench for the stepper core.
// Assumes mcu_model drives the pins; registers use the plain port.
`timescale 1ns/100ps
`default_nettype none
module tb_stepper_core;
  import stepper_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_clear_input = 1'b0;
  logic [4:0] rnd = 5'h0;
  logic [31:0] o_rdata;
  logic [7:0] o_x_setpoint, o_y_setpoint;
  logic o_bridge_enable;
  logic [3:0] o_slope_on_code, o_slope_off_code, o_hs_src_up, o_hs_src_dn, o_hs_sw_up, o_hs_sw_dn;
  logic [3:0] o_ls_src_up, o_ls_src_dn, o_ls_sw_up, o_ls_sw_dn;
  logic [7:0] o_table_position;
  logic o_x_negative, o_y_negative;
  logic [2:0] o_pin_out, o_pin_oe_n, lvl_q;
  wire logic step_pin, dir_pin, cs_n;
  int fail_count = 0;
  int comparisons = 0;
  int seed = 90;
  logic [31:0] exp_q[$];
  logic [31:0] t;
  logic rd_d = 1'b0;
  logic [7:0] steps [8] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h20, 8'h40};

  always #2.5 i_mclk = ~i_mclk;

  mcu_model mcu (.o_step(step_pin), .o_dir(dir_pin), .o_cs_n(cs_n));
  stepper_core #(.PWM_PERIOD(200)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_chip_select_n(cs_n), .i_step_pulse_in(step_pin), .i_dir_pin(dir_pin),
    .i_clear_input(i_clear_input), .i_x_over_cur(rnd[0]), .i_y_over_cur(rnd[1]), .i_sdo_level(rnd[2]),
    .i_watchdog_out_n(rnd[3]), .i_fault_out_n(rnd[4]), .o_table_position(o_table_position),
    .o_x_setpoint(o_x_setpoint), .o_x_negative(o_x_negative), .o_y_setpoint(o_y_setpoint),
    .o_y_negative(o_y_negative), .o_bridge_enable(o_bridge_enable),
    .o_slope_on_code(o_slope_on_code), .o_slope_off_code(o_slope_off_code), .o_hs_src_up(o_hs_src_up),
    .o_hs_src_dn(o_hs_src_dn), .o_hs_sw_up(o_hs_sw_up), .o_hs_sw_dn(o_hs_sw_dn), .o_ls_src_up(o_ls_src_up),
    .o_ls_src_dn(o_ls_src_dn), .o_ls_sw_up(o_ls_sw_up), .o_ls_sw_dn(o_ls_sw_dn), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n)
  );

  always @(posedge i_mclk) begin
    rnd <= 5'($random(seed));
    rd_d <= i_rd;
    lvl_q <= rnd[4:2];
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(negedge i_mclk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      check("rdata", o_rdata, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    if (a == REG_POSITION) check("table_position", {24'h0, o_table_position}, e);
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
  endtask

  task automatic ctrl(input logic [31:0] d);
    wr(REG_CTRL, d);
    mcu.commit();
  endtask

  // Open drain never drives high; push-pull always drives
  task automatic pin_check(input logic [2:0] od);
    repeat (4) begin
      @(negedge i_mclk);
      check("pin_out", {29'h0, o_pin_out}, {29'h0, ~od & lvl_q});
      check("pin_oe_n", {29'h0, o_pin_oe_n}, {29'h0, od & lvl_q});
    end
    @(posedge i_mclk);
  endtask

  task automatic clear_pos();
    @(posedge i_mclk);
    i_clear_input <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_clear_input <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge i_mclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_SLOPE, SLOPE_RESET);
    rd(REG_TIMING, TIMING_RESET);
    rd(REG_POSITION, 32'h0);
    rd(4'hF, 32'h0);
    t = 32'($random(seed)) & 32'h00FF_FFFF;
    wr(REG_TIMING, t);
    rd(REG_TIMING, t);
    wr(REG_SLOPE, 32'h0000_005A);
    mcu.commit();
    check("slope_on", {28'h0, o_slope_on_code}, 32'hA);
    check("slope_off", {28'h0, o_slope_off_code}, 32'h5);
    for (int k = 0; k < 8; k++) begin
      ctrl(32'h8 | 32'(k) | (32'(k) << 5));
      check("enable", {31'h0, o_bridge_enable}, 32'h1);
      clear_pos();
      rd(REG_POSITION, 32'h0);
      repeat (300) @(posedge i_mclk);
      check("signs", {30'h0, o_x_negative, o_y_negative}, 32'h0);
      check("x_set", {24'h0, o_x_setpoint}, (k == 7) ? {24'h0, COIL_MAX} : 32'h0);
      check("y_set", {24'h0, o_y_setpoint}, {24'h0, COIL_MAX});
      mcu.pulse(3, 1'b0);
      rd(REG_POSITION, 32'(3 * steps[k]));
    end
    ctrl(32'h0000_001F);
    mcu.pulse(4, 1'b0);
    rd(REG_POSITION, 32'h0000_00C0);
    ctrl(32'h0000_000F);
    mcu.pulse(1, 1'b1);
    rd(REG_POSITION, 32'h0000_0080);
    ctrl(32'h0000_001F);
    mcu.pulse(1, 1'b1);
    rd(REG_POSITION, 32'h0000_0040);
    ctrl(32'h0000_000F);
    mcu.pulse(3, 1'b0);
    rd(REG_POSITION, 32'h0);
    ctrl(32'h0000_010F);
    mcu.set_idle(1'b1);
    mcu.pulse(1, 1'b0);
    rd(REG_POSITION, 32'h0000_0040);
    pin_check(3'h0);
    ctrl(32'h0000_0C07);
    check("enable", {31'h0, o_bridge_enable}, 32'h0);
    check("gates", {o_hs_sw_dn, o_ls_sw_dn, o_hs_src_up, o_hs_src_dn, o_hs_sw_up, o_ls_src_up, o_ls_src_dn,
                    o_ls_sw_up}, 32'hFF00_0000);
    pin_check(3'h6);
    repeat (3) @(posedge i_mclk);
    tally_and_finish();
  end
endmodule // tb_stepper_core
`default_nettype wire
